// ---- core/mrb_pkg.sv ----
// Shared constants and types for the mode register and burst order block
package mrb_pkg;
    localparam int MR_W          = 18;
    localparam int BL_LSB        = 0;
    localparam int BT_BIT        = 3;
    localparam int DLL_RST_BIT   = 8;
    localparam int LEN_SEL_BIT   = 12;
    localparam logic [17:0] MR_RESET = 18'h00000;
    localparam logic [1:0]  BL_FIXED8 = 2'h0;
    localparam logic [1:0]  BL_PERCMD = 2'h1;
    localparam logic [1:0]  BL_CHOP4  = 2'h2;
    localparam logic [2:0]  BA_BASE   = 3'h0;
    localparam logic [3:0]  CMD_MRS   = 4'h0;
    localparam logic [3:0]  CMD_WRITE = 4'h4;
    localparam logic [3:0]  CMD_READ  = 4'h5;
    localparam int BURST_BEATS   = 8;
    localparam int CHOP_BEATS    = 4;
    // Link clock cycles, except the sync stage count; the link clock is the timing reference of the command pins
    localparam int MRD_CK        = 4;
    localparam int MOD_CK        = 12;
    localparam int DLLK_CK       = 512;
    localparam int SYNC_STAGES   = 3;
    typedef enum {BST_IDLE, BST_READ, BST_WRITE} mrb_burst_t;
endpackage

// ---- core/mrb_order_if.sv ----
// Carrier between the burst engine and the beat order generator
`timescale 1ns/100ps
interface mrb_order_if;
    logic [2:0] start;
    logic [2:0] beat;
    logic       interleave;
    logic [2:0] offset;
    modport req (output start, output beat, output interleave, input offset);
    modport gen (input start, input beat, input interleave, output offset);
endinterface

// ---- core/mrb_burst_order.sv ----
// Column offset of one beat within an aligned eight-column block
`timescale 1ns/100ps
module mrb_burst_order
    import mrb_pkg::*;
(
    mrb_order_if.gen ord  // start, beat and type in, offset out
);
    always_comb begin
        if (ord.interleave) begin
            ord.offset = ord.start ^ ord.beat;
        end else begin
            ord.offset = {ord.start[2] ^ ord.beat[2],
                          2'(ord.start[1:0] + ord.beat[1:0])};
        end
    end
endmodule

// ---- core/mrb_top.sv ----
// Mode register storage, MRS timing and burst order engine of the memory device
//
// Notes on behaviour
// - Settings other than the DLL reset bit hold until rewrite or reset
// - Mode writes never touch the array
// - New settings take effect after tMOD
// - DLL reset needs longer than tMOD
// - Length field: chop, eight, or per command
// - Burst wraps inside aligned column block
// - Same length for reads and writes
// - Type bit picks sequential or interleaved
// - Sequential eight: nibble wrap, then other
// - Interleaved eight: beat XOR start column
// - Chop reads: four beats, then tri-state
// - Writes ignore low start bits
// - Chop and eight start same clock
`timescale 1ns/100ps
module mrb_top
    import mrb_pkg::*;
#(
    parameter int DQ_W     = 8,
    parameter int COL_BITS = 4
) (
    input  wire logic                core_clk,       // core clock, 250 MHz
    input  wire logic                arst_n,         // async reset, active low
    input  wire logic                link_clk,       // command clock from controller
    input  wire logic                cke,            // clock enable pin
    input  wire logic                cs_n,           // chip select, active low
    input  wire logic                ras_n,          // row strobe, active low
    input  wire logic                cas_n,          // column strobe, active low
    input  wire logic                we_n,           // write enable, active low
    input  wire logic [2:0]          ba,             // bank address
    input  wire logic [MR_W-1:0]     addr,           // address pins
    input  wire logic [DQ_W-1:0]     dq_in,          // data pins, input side
    output logic      [DQ_W-1:0]     dq_out,         // data pins, output side
    output logic                     dq_oe,          // data pins drive enable
    output logic                     dqs_out,        // strobe, output side
    output logic                     dqs_oe,         // strobe drive enable
    output logic                     link_mod_busy,  // settings update pending
    output logic                     link_dll_locked,// DLL lock time elapsed
    output logic      [MR_W-1:0]     core_mode,      // base mode register, core copy
    output logic                     core_mode_new,  // one cycle on each new copy
    output logic                     core_dll_locked,// lock state, core domain
    output logic                     core_mod_busy   // update pending, core domain
);
    localparam int CNT_W = $clog2(DLLK_CK + 1);

    if (COL_BITS < 4 || DQ_W < 1) begin : g_chk
        $error("COL_BITS must be at least 4 and DQ_W at least 1");
    end

    // Command decode on the link clock
    logic [3:0] cmd;
    logic       is_mrs;
    logic       is_rd;
    logic       is_wr;
    assign cmd    = {cs_n, ras_n, cas_n, we_n};
    assign is_mrs = cke && cmd == CMD_MRS && ba == BA_BASE;
    assign is_rd  = cke && cmd == CMD_READ;
    assign is_wr  = cke && cmd == CMD_WRITE;

    // Programmed and effective settings
    logic [MR_W-1:0]  mode_reg;
    logic [MR_W-1:0]  active_mode;
    logic [CNT_W-1:0] mrd_cnt;
    logic [CNT_W-1:0] mod_cnt;
    logic [CNT_W-1:0] dll_cnt;
    logic             dll_start;
    logic             mrs_ok;
    assign mrs_ok = is_mrs && mrd_cnt == '0;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= MR_RESET;
        end else if (mrs_ok) begin
            mode_reg <= addr;
        end else if (mode_reg[DLL_RST_BIT]) begin
            mode_reg[DLL_RST_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            mrd_cnt <= '0;
        end else if (mrs_ok) begin
            mrd_cnt <= CNT_W'(MRD_CK - 1);
        end else if (mrd_cnt != '0) begin
            mrd_cnt <= mrd_cnt - 1'b1;
        end
    end

    // Features held back until tMOD has run out
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            mod_cnt <= '0;
        end else if (mrs_ok) begin
            mod_cnt <= CNT_W'(MOD_CK);
        end else if (mod_cnt != '0) begin
            mod_cnt <= mod_cnt - 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_mode <= MR_RESET;
        end else if (mod_cnt == CNT_W'(1)) begin
            active_mode <= mode_reg;
        end
    end

    assign dll_start = mrs_ok && addr[DLL_RST_BIT];

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            dll_cnt <= '0;
        end else if (dll_start) begin
            dll_cnt <= CNT_W'(DLLK_CK);
        end else if (dll_cnt != '0) begin
            dll_cnt <= dll_cnt - 1'b1;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_mod_busy   <= 1'b0;
            link_dll_locked <= 1'b0;
        end else begin
            link_mod_busy   <= mrs_ok || mod_cnt > CNT_W'(1);
            link_dll_locked <= !dll_start && dll_cnt <= CNT_W'(1);
        end
    end

    // Burst engine
    mrb_burst_t       bst;
    logic [2:0]       beat;
    logic             chop;
    logic             ilv;
    logic [2:0]       start;
    logic [COL_BITS-4:0] blk;
    logic             new_chop;
    logic [DQ_W-1:0]  mem [2**COL_BITS];
    logic [COL_BITS-1:0] col_idx;
    logic             beat_live;

    mrb_order_if ord ();
    mrb_burst_order u_order (
        .ord (ord.gen)
    );

    always_comb begin
        case (active_mode[BL_LSB+1:BL_LSB])
            BL_FIXED8: new_chop = 1'b0;
            BL_PERCMD: new_chop = !addr[LEN_SEL_BIT];
            BL_CHOP4:  new_chop = 1'b1;
            default:   new_chop = 1'b0;
        endcase
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            bst   <= BST_IDLE;
            beat  <= 3'h0;
            chop  <= 1'b0;
            ilv   <= 1'b0;
            start <= 3'h0;
            blk   <= '0;
        end else begin
            case (bst)
                BST_IDLE: begin
                    if ((is_rd || is_wr) && mod_cnt == '0) begin
                        bst   <= is_rd ? BST_READ : BST_WRITE;
                        beat  <= 3'h0;
                        chop  <= new_chop;
                        ilv   <= active_mode[BT_BIT];
                        blk   <= addr[COL_BITS-1:3];
                        if (is_rd) begin
                            start <= addr[2:0];
                        end else begin
                            start <= {new_chop & addr[2], 2'h0};
                        end
                    end
                end
                BST_READ, BST_WRITE: begin
                    beat <= beat + 3'h1;
                    if (beat == 3'(BURST_BEATS - 1)) begin
                        bst <= BST_IDLE;
                    end
                end
                default: bst <= BST_IDLE;
            endcase
        end
    end

    assign ord.start      = start;
    assign ord.beat       = beat;
    assign ord.interleave = ilv;
    assign col_idx        = {blk, ord.offset};
    assign beat_live      = !chop || beat < 3'(CHOP_BEATS);

    // Array is touched only by bursts, never by MRS
    always_ff @(posedge link_clk) begin
        if (bst == BST_WRITE && beat_live) begin
            mem[col_idx] <= dq_in;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_out  <= '0;
            dq_oe   <= 1'b0;
            dqs_out <= 1'b0;
            dqs_oe  <= 1'b0;
        end else if (bst == BST_READ && beat_live) begin
            dq_out  <= mem[col_idx];
            dq_oe   <= 1'b1;
            dqs_out <= !beat[0];
            dqs_oe  <= 1'b1;
        end else begin
            dq_out  <= '0;
            dq_oe   <= 1'b0;
            dqs_out <= 1'b0;
            dqs_oe  <= 1'b0;
        end
    end

    // Toggle handshake carrying the effective settings to the core clock
    logic            req_tgl;
    logic            send_pend;
    logic [MR_W-1:0] xfer_word;
    logic [SYNC_STAGES-1:0] ack_sync;
    logic            ack_seen;
    logic [SYNC_STAGES-1:0] req_sync;
    logic            core_ack;
    logic [SYNC_STAGES-1:0] lock_sync;
    logic [SYNC_STAGES-1:0] busy_sync;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_sync <= '0;
            ack_seen <= 1'b0;
        end else begin
            ack_sync <= {ack_sync[SYNC_STAGES-2:0], core_ack};
            if (ack_sync[1] == ack_sync[2]) begin
                ack_seen <= ack_sync[2];
            end
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_tgl   <= 1'b0;
            send_pend <= 1'b0;
            xfer_word <= MR_RESET;
        end else begin
            if (mod_cnt == CNT_W'(1)) begin
                send_pend <= 1'b1;
            end else if (send_pend && req_tgl == ack_seen) begin
                send_pend <= 1'b0;
                xfer_word <= active_mode;
                req_tgl   <= !req_tgl;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_sync      <= '0;
            core_ack      <= 1'b0;
            core_mode     <= MR_RESET;
            core_mode_new <= 1'b0;
        end else begin
            req_sync      <= {req_sync[SYNC_STAGES-2:0], req_tgl};
            core_mode_new <= 1'b0;
            if (req_sync[1] == req_sync[2] && req_sync[2] != core_ack) begin
                core_mode     <= xfer_word;
                core_mode_new <= 1'b1;
                core_ack      <= req_sync[2];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_sync       <= '0;
            busy_sync       <= '0;
            core_dll_locked <= 1'b0;
            core_mod_busy   <= 1'b0;
        end else begin
            lock_sync <= {lock_sync[SYNC_STAGES-2:0], link_dll_locked};
            busy_sync <= {busy_sync[SYNC_STAGES-2:0], link_mod_busy};
            if (lock_sync[1] == lock_sync[2]) begin
                core_dll_locked <= lock_sync[2];
            end
            if (busy_sync[1] == busy_sync[2]) begin
                core_mod_busy <= busy_sync[2];
            end
        end
    end
endmodule

// ---- bench/mrb_top_chk.sv ----
// Port assertions for the mode register and burst engine
`timescale 1ns/100ps
module mrb_top_chk
    import mrb_pkg::*;
#(
    parameter int DQ_W     = 8,
    parameter int COL_BITS = 4
) (
    input wire logic            core_clk,        // core
    input wire logic            arst_n,          // reset
    input wire logic            link_clk,        // link
    input wire logic            cke,             // enable
    input wire logic            cs_n,            // select
    input wire logic            ras_n,           // row
    input wire logic            cas_n,           // column
    input wire logic            we_n,            // write
    input wire logic [2:0]      ba,              // bank
    input wire logic [MR_W-1:0] addr,            // address
    input wire logic [DQ_W-1:0] dq_in,           // data in
    input wire logic [DQ_W-1:0] dq_out,          // data out
    input wire logic            dq_oe,           // data enable
    input wire logic            dqs_out,         // strobe
    input wire logic            dqs_oe,          // strobe enable
    input wire logic            link_mod_busy,   // busy
    input wire logic            link_dll_locked, // locked
    input wire logic [MR_W-1:0] core_mode,       // mode copy
    input wire logic            core_mode_new,   // load pulse
    input wire logic            core_dll_locked, // locked copy
    input wire logic            core_mod_busy    // busy copy
);
    logic [9:0] low_cnt;
    logic       rd_cmd;
    logic       mrs_cmd;
    assign rd_cmd  = cke && {cs_n, ras_n, cas_n, we_n} == CMD_READ;
    assign mrs_cmd = cke && {cs_n, ras_n, cas_n, we_n} == CMD_MRS && !link_mod_busy;
    // Link cycles spent without lock
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n)
            low_cnt <= 10'h000;
        else
            low_cnt <= link_dll_locked ? 10'h000 : low_cnt + 10'h001;
    end
    mrs_busy_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        mrs_cmd && ba == BA_BASE |=> link_mod_busy) else $error("mrs not taken");
    bank_sel_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        mrs_cmd && ba != BA_BASE |=> !link_mod_busy) else $error("other bank taken");
    busy_len_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(link_mod_busy) |-> link_mod_busy [*8] ##1 link_mod_busy [*4] ##1 !link_mod_busy)
        else $error("busy length wrong");
    read_lat_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        rd_cmd && !link_mod_busy && !dq_oe |-> ##2 dq_oe && dqs_out) else $error("read late");
    refuse_rd_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        rd_cmd && link_mod_busy |-> ##2 !dq_oe) else $error("read during update");
    oe_pair_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        dq_oe == dqs_oe) else $error("enables differ");
    strobe_seq_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(dq_oe) |-> dqs_out ##1 !dqs_out ##1 dqs_out ##1 !dqs_out) else $error("strobe");
    burst_len_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(dq_oe) |-> dq_oe [*4] ##1 (dq_oe [*4] or (!dq_oe) [*4]) ##1 !dq_oe)
        else $error("burst length wrong");
    idle_zero_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        !dq_oe |-> dq_out == '0) else $error("data while off");
    dll_time_a: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(link_dll_locked) |-> low_cnt <= 10'h002 || (low_cnt >= 10'h1FE && low_cnt <= 10'h202))
        else $error("lock time wrong");
    core_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !core_mode_new |-> $stable(core_mode)) else $error("mode changed silently");
    dll_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        core_mode_new |-> !core_mode[DLL_RST_BIT]) else $error("reset bit kept");
    cover property (@(posedge link_clk) disable iff (!arst_n) $rose(dq_oe));
    cover property (@(posedge link_clk) disable iff (!arst_n) mrs_cmd && ba == BA_BASE);
    cover property (@(posedge link_clk) disable iff (!arst_n) $rose(link_dll_locked));
endmodule
bind mrb_top mrb_top_chk #(.DQ_W(DQ_W), .COL_BITS(COL_BITS)) i_chk (
    .core_clk, .arst_n, .link_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_in,
    .dq_out, .dq_oe, .dqs_out, .dqs_oe, .link_mod_busy, .link_dll_locked, .core_mode,
    .core_mode_new, .core_dll_locked, .core_mod_busy
);

// ---- bench/mrb_ctrl_model.sv ----
// Controller model driving command and data pins on the link clock
`timescale 1ns/100ps
module mrb_ctrl_model
    import mrb_pkg::*;
(
    input  wire logic            link_clk, // link
    output logic                 cke,      // enable
    output logic                 cs_n,     // select
    output logic                 ras_n,    // row
    output logic                 cas_n,    // column
    output logic                 we_n,     // write
    output logic [2:0]           ba,       // bank
    output logic [MR_W-1:0]      addr,     // address
    output logic [7:0]           dq_in,    // write data
    input  wire logic [7:0]      dq_out,   // read data
    input  wire logic            dq_oe,    // data enable
    input  wire logic            dqs_out   // strobe
);
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = 3'h0;
        addr = 18'h00000;
        dq_in = 8'h5A;
    end
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [MR_W-1:0] a);
        @(negedge link_clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(negedge link_clk);
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        addr = ~a;
    endtask
    // Whole word, reserved bits cleared, only when no burst runs
    task automatic mrs(input logic [MR_W-1:0] v);
        cmd(CMD_MRS, BA_BASE, v & ~18'h26080);
        // Only NOP while settling; termination is never enabled by this model
        repeat (v[8] ? 520 : 14) @(negedge link_clk);
    endtask
    task automatic wr(input logic [MR_W-1:0] a, input logic [7:0] base);
        cmd(CMD_WRITE, BA_BASE, a);
        for (int k = 0; k < 8; k++) begin
            dq_in = base + 8'(k);
            @(negedge link_clk);
        end
        dq_in = ~dq_in;
        @(negedge link_clk);
    endtask
    task automatic rd(input logic [MR_W-1:0] a, output logic [63:0] d, output logic [7:0] oe,
                      output logic [7:0] st);
        cmd(CMD_READ, BA_BASE, a);
        for (int k = 0; k < 8; k++) begin
            @(negedge link_clk);
            d[8*k+:8] = dq_out;
            oe[k] = dq_oe;
            st[k] = dqs_out;
        end
    endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for mode register and burst order behaviour
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
    import mrb_pkg::*;
    logic            core_clk, link_clk, arst_n, cke, cs_n, ras_n, cas_n, we_n;
    logic            dq_oe, dqs_out, dqs_oe, link_mod_busy, link_dll_locked;
    logic            core_mode_new, core_dll_locked, core_mod_busy;
    logic [2:0]      ba;
    logic [MR_W-1:0] addr, core_mode;
    logic [7:0]      dq_in, dq_out;
    int              bad_count = 0;
    int              compares = 0;
    mrb_top #(.DQ_W(8), .COL_BITS(4)) i_dut (
        .core_clk, .arst_n, .link_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
        .dq_in, .dq_out, .dq_oe, .dqs_out, .dqs_oe, .link_mod_busy, .link_dll_locked,
        .core_mode, .core_mode_new, .core_dll_locked, .core_mod_busy
    );
    mrb_ctrl_model i_ctrl (
        .link_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_in, .dq_out, .dq_oe,
        .dqs_out
    );
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Column data is A0 plus the column number
    task automatic rd_chk(input logic [MR_W-1:0] a, input logic il, input logic chop);
        logic [63:0] d;
        logic [7:0]  oe;
        logic [7:0]  st;
        logic [2:0]  c;
        logic        on;
        i_ctrl.rd(a, d, oe, st);
        for (int k = 0; k < 8; k++) begin
            on = !(chop && k >= 4);
            c = il ? a[2:0] ^ 3'(k) : {a[2] ^ k[2], a[1:0] + 2'(k)};
            `CHK(oe[k], on)
            if (on) begin
                `CHK(d[8*k+:8], 8'hA0 + 8'({a[3], c}))
                `CHK(st[k], ~k[0])
            end
        end
    endtask
    task automatic t_fill;
        `CHK(core_mode, MR_RESET)
        i_ctrl.mrs(MR_RESET);
        i_ctrl.wr(18'h00005, 8'hA0);
        i_ctrl.wr(18'h0000E, 8'hA8);
    endtask
    task automatic t_refuse;
        logic [63:0] d;
        logic [7:0]  oe;
        logic [7:0]  st;
        // Clock enable low: the command must be ignored
        i_ctrl.cke = 1'b0;
        i_ctrl.cmd(CMD_MRS, BA_BASE, 18'h00008);
        i_ctrl.cke = 1'b1;
        i_ctrl.cmd(CMD_MRS, 3'h2, 18'h00008);
        repeat (14) @(negedge link_clk);
        rd_chk(18'h00001, 1'b0, 1'b0);
        i_ctrl.cmd(CMD_MRS, BA_BASE, 18'h00000);
        repeat (3) @(negedge link_clk);
        `CHK(core_mod_busy, 1'b1)
        i_ctrl.rd(18'h00000, d, oe, st);
        `CHK(oe, 8'h00)
        repeat (14) @(negedge link_clk);
        `CHK(core_mod_busy, 1'b0)
    endtask
    task automatic t_len(input logic [1:0] bl, input logic il, input logic chop);
        i_ctrl.mrs({14'h0000, il, 1'b0, bl});
        for (int s = 0; s < 8; s++) begin
            rd_chk({14'h0000, s[0], 3'(s)}, il, chop);
        end
    endtask
    task automatic t_per_cmd;
        i_ctrl.mrs({16'h0000, BL_PERCMD});
        rd_chk(18'h00006, 1'b0, 1'b1);
        rd_chk(18'h0100A, 1'b0, 1'b0);
        // Chop write ignores the low start bits and fills one nibble only
        i_ctrl.wr(18'h0000D, 8'hAC);
        rd_chk(18'h0000C, 1'b0, 1'b1);
    endtask
    task automatic t_mode;
        i_ctrl.cmd(CMD_MRS, BA_BASE, 18'h11F09);
        repeat (20) @(negedge link_clk);
        `CHK(link_dll_locked, 1'b0)
        `CHK(core_mode, 18'h11E09)
        repeat (520) @(negedge link_clk);
        `CHK(link_dll_locked, 1'b1)
        `CHK(core_dll_locked, 1'b1)
        rd_chk(18'h01003, 1'b1, 1'b0);
    endtask
    initial begin
        arst_n = 1'b0;
        repeat (10) @(negedge link_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        t_fill;
        t_refuse;
        t_len(BL_FIXED8, 1'b0, 1'b0);
        t_len(BL_FIXED8, 1'b1, 1'b0);
        t_len(BL_CHOP4, 1'b0, 1'b1);
        t_len(BL_CHOP4, 1'b1, 1'b1);
        t_len(2'h3, 1'b1, 1'b0);
        t_per_cmd;
        t_mode;
        final_report;
    end
    initial begin
        #200000;
        bad_count++;
        final_report;
    end
endmodule
